// ===== tmrps_pkg.sv
// Purpose: Constants for the timer with shared prescaler
// Assumes: One 40 MHz clock; four clock periods form one instruction cycle
// Notes: Register offsets are local choices on a plain register port
//
// Functional notes
// - Source select zero: count one per instruction cycle without prescaler
// - After a counter write, no increment for the next two instruction cycles
// - Source select one: count edges of the external counter input
// - Edge select zero counts rising edges, one counts falling edges
// - Prescaler serves timer when assign bit is zero, watchdog when one
// - Three-bit rate field picks timer ratio from 1:2 to 1:256
// - Prescaler is an 8-bit counter, before timer or after watchdog
// - With prescaler on timer, any counter write clears the prescaler
// - With prescaler on watchdog, watchdog clear clears prescaler and watchdog
// - Prescaler not software accessible; reset loads it with zeros
// - Count input sampled in phase two and phase four of each cycle
// - Counter increments only after synchronization, with short latency
// - Counter is an 8-bit read and write register
// - External input synchronized before the prescaler divides it
package tmrps_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [1:0] ADDR_COUNT = 2'h0;
  localparam logic [1:0] ADDR_OPTION = 2'h1;
  localparam logic [1:0] ADDR_WDT_CLR = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SCALER_RESET = 8'h00;
  localparam logic [7:0] WDT_RESET = 8'h00;
  // ------------------------------------------------------------
  // Option field positions
  // ------------------------------------------------------------
  localparam int OPT_SRC = 5;
  localparam int OPT_EDGE = 4;
  localparam int OPT_PSA = 3;
  localparam int OPT_RATE_HI = 2;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
endpackage : tmrps_pkg

// ===== tmrps_sync.sv
// Purpose: Two flip-flop synchronizer for the external count pin
// Assumes: Input is asynchronous to ref_clk
// Notes: Only the second stage is visible outside
module tmrps_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync_out;

  // Shift the pin through two stages
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // Register stages
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule : tmrps_sync

// ===== tmrps_top.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog
// Assumes: Register port strobes are one cycle, read data one cycle later
// Notes: Prescaler counts synchronized pin edges in counter mode when it serves the timer
module tmrps_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_count_input,
  output logic [7:0] timer_count,
  output logic [7:0] watchdog_counter,
  output logic watchdog_tick,
  output logic [1:0] phase
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  // Two-stage reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------
  logic [7:0] timer_option_settings;
  logic [7:0] scaler;
  logic [1:0] inhibit;
  logic pin_sync;
  logic pin_smp;
  logic pin_smp_d;
  logic [7:0] next_timer_count;
  logic [7:0] next_option;
  logic [7:0] next_scaler;
  logic [7:0] next_wdt;
  logic [1:0] next_inhibit;
  logic [1:0] next_phase;
  logic [7:0] next_rdata;
  logic next_pin_smp;
  logic next_pin_smp_d;
  logic next_wdt_tick;
  logic src_ext;
  logic edge_fall;
  logic to_wdt;
  logic [2:0] rate;
  logic [7:0] rate_mask;
  logic wr_count;
  logic wr_option;
  logic wdt_clr;
  logic instr_end;
  logic sample_now;
  logic pin_edge;
  logic scaler_clk;
  logic scaler_carry;
  logic wdt_ovf;
  logic base_tick;
  logic inc;

  tmrps_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(external_count_input),
    .sync_out(pin_sync)
  );

  // Option field decode
  assign src_ext = timer_option_settings[tmrps_pkg::OPT_SRC];
  assign edge_fall = timer_option_settings[tmrps_pkg::OPT_EDGE];
  assign to_wdt = timer_option_settings[tmrps_pkg::OPT_PSA];
  assign rate = timer_option_settings[tmrps_pkg::OPT_RATE_HI:0];
  assign wr_count = reg_wr && (reg_addr == tmrps_pkg::ADDR_COUNT);
  assign wr_option = reg_wr && (reg_addr == tmrps_pkg::ADDR_OPTION);
  assign wdt_clr = reg_wr && (reg_addr == tmrps_pkg::ADDR_WDT_CLR);
  assign instr_end = (phase == tmrps_pkg::PHASE_FOUR);
  assign sample_now = (phase == tmrps_pkg::PHASE_TWO) ||
                      (phase == tmrps_pkg::PHASE_FOUR);

  // Counted edge of the pin, judged once in the cycle after each sample
  // so that one pin edge never yields two ticks
  assign pin_edge = !sample_now &&
                    (edge_fall ? (pin_smp_d && !pin_smp)
                               : (!pin_smp_d && pin_smp));

  // Source for timer and prescaler
  assign base_tick = src_ext ? pin_edge : instr_end;

  // Watchdog overflow at the end of an instruction cycle
  assign wdt_ovf = (watchdog_counter == 8'hFF) && instr_end;

  // Prescaler advance: timer source, held during inhibit, or watchdog
  assign scaler_clk = to_wdt ? wdt_ovf
                             : (base_tick && inhibit == 2'h0);

  // Per-bit mask of the prescaler stages up to the selected tap
  for (genvar i = 0; i < 8; i++) begin : g_rate_mask
    assign rate_mask[i] = (3'(i) <= rate);
  end

  // Carry out of the selected stage: one output per 2 to 256 inputs
  assign scaler_carry = scaler_clk && (&(scaler | ~rate_mask));

  // Timer increment after sync, prescaled carry or direct source
  assign inc = (to_wdt ? base_tick : scaler_carry) &&
               (inhibit == 2'h0);

  // ------------------------------------------------------------
  // Phase counter
  // ------------------------------------------------------------
  // Four phases make one instruction cycle
  always_comb begin
    next_phase = phase + 2'h1;
  end

  // Register the phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  // Sample the synchronized pin in phase two and phase four
  always_comb begin
    next_pin_smp = sample_now ? pin_sync : pin_smp;
    next_pin_smp_d = sample_now ? pin_smp : pin_smp_d;
  end

  // Register the two samples; reset matches the idle low pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_smp <= 1'b0;
      pin_smp_d <= 1'b0;
    end else begin
      pin_smp <= next_pin_smp;
      pin_smp_d <= next_pin_smp_d;
    end
  end

  // ------------------------------------------------------------
  // Option settings
  // ------------------------------------------------------------
  // Software loads the option byte
  always_comb begin
    next_option = wr_option ? reg_wdata : timer_option_settings;
  end

  // Register the options
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_option_settings <= tmrps_pkg::OPTION_RESET;
    end else begin
      timer_option_settings <= next_option;
    end
  end

  // ------------------------------------------------------------
  // Shared prescaler
  // ------------------------------------------------------------
  // Count, and clear on the access that belongs to the current owner
  always_comb begin
    next_scaler = scaler_clk ? scaler + 8'h01 : scaler;
    if (wr_count && !to_wdt) begin
      next_scaler = tmrps_pkg::SCALER_RESET;
    end
    if (wdt_clr && to_wdt) begin
      next_scaler = tmrps_pkg::SCALER_RESET;
    end
  end

  // Register the prescaler; it has no register address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scaler <= tmrps_pkg::SCALER_RESET;
    end else begin
      scaler <= next_scaler;
    end
  end

  // ------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------
  // Count instruction cycles; a clear restarts the period
  always_comb begin
    next_wdt = instr_end ? watchdog_counter + 8'h01 : watchdog_counter;
    // Period end: direct overflow or postscaled carry
    next_wdt_tick = to_wdt ? scaler_carry : wdt_ovf;
    if (wdt_clr) begin
      next_wdt = tmrps_pkg::WDT_RESET;
      next_wdt_tick = 1'b0;
    end
  end

  // Register the watchdog count and its tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter <= tmrps_pkg::WDT_RESET;
      watchdog_tick <= 1'b0;
    end else begin
      watchdog_counter <= next_wdt;
      watchdog_tick <= next_wdt_tick;
    end
  end

  // ------------------------------------------------------------
  // Timer count and write inhibit
  // ------------------------------------------------------------
  // A write loads the count and starts the inhibit; it wins over a tick
  always_comb begin
    next_inhibit = (inhibit != 2'h0 && instr_end) ? inhibit - 2'h1 : inhibit;
    if (wr_count) begin
      next_timer_count = reg_wdata;
      next_inhibit = tmrps_pkg::INHIBIT_CYCLES;
    end else if (inc) begin
      next_timer_count = timer_count + 8'h01;
    end else begin
      next_timer_count = timer_count;
    end
  end

  // Register the count and the inhibit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inhibit <= 2'h0;
      timer_count <= tmrps_pkg::COUNT_RESET;
    end else begin
      inhibit <= next_inhibit;
      timer_count <= next_timer_count;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Read mux; prescaler has no address
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        tmrps_pkg::ADDR_COUNT: next_rdata = timer_count;
        tmrps_pkg::ADDR_OPTION: next_rdata = timer_option_settings;
        tmrps_pkg::ADDR_WDT_CLR: next_rdata = watchdog_counter;
        tmrps_pkg::ADDR_STATUS: next_rdata = {6'h00, inhibit};
      endcase
    end
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_count_write;
    reg_wr && reg_addr == tmrps_pkg::ADDR_COUNT;
  endsequence

  AST_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_count_write |=> timer_count == $past(reg_wdata))
    else $error("counter write not stored");
  AST_INHIBIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_count_write ##1 !reg_wr [*5] |-> $stable(timer_count))
    else $error("counter moved during inhibit");
  AST_TIMER_RATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!src_ext && to_wdt && inhibit == 2'h0 && instr_end && !reg_wr)
    |=> timer_count == $past(timer_count) + 8'h01)
    else $error("timer missed instruction cycle");
  AST_NO_MID_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!src_ext && !instr_end && !reg_wr) |=> $stable(timer_count))
    else $error("timer moved mid cycle");
  AST_PS_CLR_TMR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_count && !to_wdt) |=> scaler == 8'h00)
    else $error("prescaler not cleared on counter write");
  AST_PS_CLR_WDT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wdt_clr && to_wdt) |=> scaler == 8'h00 &&
    watchdog_counter == 8'h00)
    else $error("watchdog clear missed");
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (timer_count == 8'hFF && inc && !reg_wr) |=> timer_count == 8'h00)
    else $error("counter did not wrap");
  AST_EXT_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (src_ext && !reg_wr && !pin_edge) |=> $stable(timer_count))
    else $error("counter moved without pin edge");
  AST_SAMPLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (phase == 2'h0 || phase == 2'h2) |=> $stable(pin_smp))
    else $error("pin sampled outside phase two or four");

  // Prescaled carry with no write pending
  sequence s_prescaled_tick;
    !to_wdt && scaler_carry && inhibit == 2'h0 && !reg_wr;
  endsequence

  // Prescaler on the timer with no carry and no write
  sequence s_tap_quiet;
    !to_wdt && !scaler_carry && !reg_wr;
  endsequence

  AST_PS_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_prescaled_tick |=> timer_count == $past(timer_count) + 8'h01)
    else $error("prescaled carry missed");
  AST_PS_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_tap_quiet |=> $stable(timer_count))
    else $error("timer moved without prescaled carry");
  AST_PS_INHIBIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!to_wdt && inhibit != 2'h0 && !reg_wr) |=> $stable(scaler))
    else $error("prescaler moved during inhibit");
  AST_WDT_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdt_clr |=> watchdog_counter == 8'h00 && !watchdog_tick)
    else $error("watchdog clear did not restart period");
  AST_TICK_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!to_wdt && wdt_ovf && !wdt_clr) |=> watchdog_tick)
    else $error("watchdog overflow tick missed");
  AST_TICK_POST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (to_wdt && !wdt_ovf) |=> !watchdog_tick)
    else $error("postscaled tick without overflow");
  AST_EDGE_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin_edge |=> !pin_edge)
    else $error("pin edge seen twice");
  AST_RD_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == tmrps_pkg::ADDR_COUNT)
    |=> reg_rdata == $past(timer_count))
    else $error("count read data wrong");
  AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : tmrps_top

// ===== tmrps_ext_src.sv
// Purpose: Model of the clock source on the count pin
// Assumes: One oscillator period is one 25 ns ref_clk period
// Notes: Pin is always driven; it idles low between bursts
module tmrps_ext_src (
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Two periods plus the RC allowance
  localparam int MIN_NS = 75;
  initial pin = 1'b0;
  // Drive a level, never shorter than the minimum width
  task automatic hold(input logic v, input int ns);
    pin = v;
    #((ns < MIN_NS) ? MIN_NS : ns);
  endtask : hold
endmodule : tmrps_ext_src

// ===== tb_tmrps_top.sv
// Purpose: Self-checking bench for the timer with shared prescaler
// Assumes: Four ref_clk periods make one instruction cycle
// Notes: Register port is driven just after rising edges
module tb_tmrps_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, timer_count, watchdog_counter;
  logic watchdog_tick, ext_pin;
  logic [1:0] phase;
  int n_mismatch = 0;
  int comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  tmrps_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_count_input(ext_pin),
    .timer_count(timer_count), .watchdog_counter(watchdog_counter),
    .watchdog_tick(watchdog_tick), .phase(phase));
  tmrps_ext_src src (.pin(ext_pin));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("Counts: %0d compares, %0d bad", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chk_n(input int g, input int lo, input int hi, string m);
    comparisons++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, g);
    end
  endtask : chk_n
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Count edges until the timer value moves, bounded
  task automatic wait_chg(output int n);
    logic [7:0] p;
    p = timer_count;
    n = 0;
    while (timer_count === p) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 3000) begin
        chk_n(n, 0, 3000, "timer stuck");
        end_sim();
      end
    end
  endtask : wait_chg
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    rd(tmrps_pkg::ADDR_OPTION, d);
    chk(d, tmrps_pkg::OPTION_RESET, "option reset");
    rd(tmrps_pkg::ADDR_COUNT, d);
    chk(d, tmrps_pkg::COUNT_RESET, "count reset");
    $display("done: reset");
  endtask : t_reset
  task automatic t_timer();
    int n;
    wr(tmrps_pkg::ADDR_OPTION, 8'h08);
    wr(tmrps_pkg::ADDR_COUNT, 8'hFE);
    #1 chk(timer_count, 8'hFE, "load");
    wait_chg(n);
    chk_n(n, 8, 12, "hold off");
    wait_chg(n);
    chk_n(n, 4, 4, "timer rate");
    chk(timer_count, 8'h00, "wrap");
    $display("done: timer");
  endtask : t_timer
  task automatic t_scale();
    int n;
    for (int r = 0; r < 8; r++) begin
      wr(tmrps_pkg::ADDR_OPTION, {5'h00, r[2:0]});
      wr(tmrps_pkg::ADDR_COUNT, 8'h00);
      #1 wait_chg(n);
      chk_n(n, (8 << r) + 5, (8 << r) + 8, "clr");
      wait_chg(n);
      chk_n(n, 4 << (r + 1), 4 << (r + 1), "ratio");
    end
    $display("done: prescale");
  endtask : t_scale
  task automatic t_edge();
    logic [7:0] c;
    for (int e = 0; e < 2; e++) begin
      wr(tmrps_pkg::ADDR_OPTION, 8'h28 | (e[0] ? 8'h10 : 8'h00));
      #3 src.hold(1'b0, 200);
      c = timer_count;
      src.hold(1'b1, 300);
      chk(timer_count, c + {7'h00, ~e[0]}, "rise");
      src.hold(1'b0, 300);
      chk(timer_count, c + 8'h01, "fall");
    end
    $display("done: edges");
  endtask : t_edge
  task automatic t_ext_scale();
    wr(tmrps_pkg::ADDR_OPTION, 8'h20);
    wr(tmrps_pkg::ADDR_COUNT, 8'h00);
    #3 src.hold(1'b0, 300);
    for (int i = 0; i < 8; i++) begin
      src.hold(1'b1, 100);
      src.hold(1'b0, 100);
    end
    src.hold(1'b0, 300);
    chk(timer_count, 8'h04, "ext div2");
    $display("done: ext prescale");
  endtask : t_ext_scale
  task automatic t_wdt();
    int n;
    wr(tmrps_pkg::ADDR_OPTION, 8'h0F);
    repeat (40) @(posedge ref_clk);
    wr(tmrps_pkg::ADDR_WDT_CLR, 8'h00);
    #1 chk(watchdog_counter, 8'h00, "wdt clear");
    wait_chg(n);
    wait_chg(n);
    chk_n(n, 4, 4, "no timer scale");
    wr(tmrps_pkg::ADDR_OPTION, 8'h07);
    wr(tmrps_pkg::ADDR_WDT_CLR, 8'h00);
    #1 n = 0;
    while (watchdog_tick !== 1'b1 && n < 1100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk_n(n, 1021, 1024, "watchdog period");
    $display("done: watchdog");
  endtask : t_wdt
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_timer();
    t_scale();
    t_edge();
    t_ext_scale();
    t_wdt();
    end_sim();
  end
endmodule : tb_tmrps_top
